/* hps_host_model.sv */
// Host processor model that runs accesses in all bus flavours.
// Assumes the bench calls one access at a time.
`timescale 1ns/1ps
module hps_host_model (
   // Clocks.
   input wire logic clk,
   input wire logic hostClk,
   // Port pins.
   output logic selN,
   output logic xferStartN,
   output logic wrRwN,
   output logic rdWeN,
   output logic [2:0] busType,
   output logic [10:0] addr,
   output logic [7:0] dataI,
   input wire logic [7:0] dataO,
   input wire logic oeN,
   input wire logic ackN,
   input wire logic [4:0] cascN
);
   initial begin
      selN = 1'b1;
      xferStartN = 1'b1;
      wrRwN = 1'b1;
      rdWeN = 1'b1;
      busType = 3'h0;
      addr = 11'h000;
      dataI = 8'h00;
   end
   // Synchronous accesses are paced by hostClk, the rest by clk.
   task automatic access(input logic [2:0] bt, input logic rd,
      input logic [10:0] a, input logic [7:0] wd, output logic ok,
      output logic [7:0] rdat, output logic [4:0] cs);
      int n;
      ok = 1'b0;
      if (bt == 3'h7) @(negedge hostClk);
      else @(negedge clk);
      busType = bt;
      addr = a;
      dataI = wd;
      selN = 1'b0;
      xferStartN = (bt != 3'h7);
      wrRwN = rd;
      rdWeN = (bt == 3'h1) ? 1'b0 : (bt == 3'h7) ? 1'b1 : !rd;
      for (n = 0; n < 40 && !ok; n++) begin
         if (bt == 3'h7) @(posedge hostClk);
         else @(posedge clk);
         ok = !ackN;
      end
      // An undriven bus shows the inverse, so a missing drive cannot pass.
      rdat = oeN ? ~dataO : dataO;
      cs = cascN;
      if (bt == 3'h7) @(negedge hostClk);
      else @(negedge clk);
      selN = 1'b1;
      xferStartN = 1'b1;
      wrRwN = 1'b1;
      rdWeN = 1'b1;
      dataI = ~wd;
      repeat (20) @(posedge clk);
   endtask
endmodule // hps_host_model

/* hps_host_port.sv */
// Host port front end: select gating, address split, cascade selects,
// register access handshake and the open-drain interrupt.
// Assumes a register file on clk that answers a read one cycle later and
// a host bus clock that runs while synchronous accesses are in flight.
`timescale 1ns/1ps
module hps_host_port (
   // Core clock, reset and enable.
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Host bus clock for the synchronous flavour.
   input wire logic hostClk,
   // Host port pins.
   input wire logic selN,
   input wire logic addrLatchXferStartN,
   input wire logic wrStrobeRwN,
   input wire logic rdStrobeWeN,
   input wire logic [2:0] hostBusTypeSelect,
   input wire logic [hps_pkg::ADDR_W-1:0] addr,
   input wire logic [hps_pkg::DATA_W-1:0] dataI,
   output logic [hps_pkg::DATA_W-1:0] dataO,
   output logic dataOeN,
   output logic readyOrXferAckN,
   input wire logic hwResetN,
   // Cascade select outputs, index 0 is cascade select 1.
   output logic [hps_pkg::NUM_CASCADE-1:0] cascadeSelectN,
   // Interrupt pin.
   output logic irqO,
   output logic irqOeN,
   // Core side.
   input wire logic globalIrqEnable,
   input wire logic [hps_pkg::ALARM_W-1:0] alarmStatus,
   output hps_pkg::hps_reg_req_t regReq,
   input wire logic [hps_pkg::DATA_W-1:0] regRdData,
   output logic regDefaults
);
   hps_pkg::hps_pins_t pinsRaw;
   hps_pkg::hps_pins_t pc;
   hps_pkg::hps_pins_t pl;
   hps_pkg::hps_cst_t c_ff;
   hps_pkg::hps_cst_t nxt_c;
   hps_pkg::hps_lst_t l_ff;
   hps_pkg::hps_lst_t nxt_l;
   logic hwRstSync;
   logic ceL;
   logic reqSync;
   logic ackSync;
   logic [2:0] devSelC;
   logic [2:0] devSelL;
   logic [hps_pkg::NUM_CASCADE-1:0] cascHit;

   assign pinsRaw = '{selN: selN, xferStartN: addrLatchXferStartN,
      wrRw: wrStrobeRwN, rdWe: rdStrobeWeN, busType: hostBusTypeSelect,
      addr: addr, data: dataI};

   // Every pin is synchronised separately into each domain that reads it.
   hps_sync2 #(.WIDTH($bits(hps_pkg::hps_pins_t)),
      .RST_VAL(hps_pkg::PINS_RST)) u_pins_c (
      .clk(clk),
      .resetn(resetn),
      .en(ce),
      .d(pinsRaw),
      .q(pc)
   );

   hps_sync2 #(.WIDTH($bits(hps_pkg::hps_pins_t)),
      .RST_VAL(hps_pkg::PINS_RST)) u_pins_l (
      .clk(hostClk),
      .resetn(resetn),
      .en(ceL),
      .d(pinsRaw),
      .q(pl)
   );

   hps_sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_rst_c (
      .clk(clk),
      .resetn(resetn),
      .en(ce),
      .d(hwResetN),
      .q(hwRstSync)
   );

   // The enable itself must keep running in the host domain.
   hps_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_ce_l (
      .clk(hostClk),
      .resetn(resetn),
      .en(1'b1),
      .d(ce),
      .q(ceL)
   );

   hps_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_req_c (
      .clk(clk),
      .resetn(resetn),
      .en(ce),
      .d(l_ff.reqTgl),
      .q(reqSync)
   );

   hps_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_ack_l (
      .clk(hostClk),
      .resetn(resetn),
      .en(ceL),
      .d(c_ff.ackTgl),
      .q(ackSync)
   );

   assign devSelC = pc.addr[hps_pkg::SEL_MSB:hps_pkg::SEL_LSB];
   assign devSelL = pl.addr[hps_pkg::SEL_MSB:hps_pkg::SEL_LSB];

   // Code 6 and code 0 match no cascade index here.
   for (genvar i = 0; i < hps_pkg::NUM_CASCADE; i++) begin : g_casc
      assign cascHit[i] = (devSelC == 3'(i + 1)) ||
         (devSelC == hps_pkg::DEVSEL_ALL);
   end

   // Core clock side: asynchronous flavours, register access, interrupt.
   always_comb begin
      logic selOn;
      logic selfHit;
      logic asyncMode;
      logic strobeOn;
      logic rdDir;
      logic changed;
      logic clearHit;
      selOn = 1'b0;
      selfHit = 1'b0;
      asyncMode = 1'b0;
      strobeOn = 1'b0;
      rdDir = 1'b0;
      changed = 1'b0;
      clearHit = 1'b0;
      nxt_c = c_ff;
      nxt_c.req.wr = 1'b0;
      nxt_c.req.rd = 1'b0;
      selOn = !pc.selN;
      selfHit = (devSelC == hps_pkg::DEVSEL_SELF) ||
         (devSelC == hps_pkg::DEVSEL_ALL);
      case (pc.busType)
         hps_pkg::BUS_ASYNC_STROBE: begin
            asyncMode = 1'b1;
            strobeOn = !pc.rdWe || !pc.wrRw;
            rdDir = !pc.rdWe;
         end
         hps_pkg::BUS_ASYNC_DS: begin
            asyncMode = 1'b1;
            strobeOn = !pc.rdWe;
            rdDir = pc.wrRw;
         end
         default: begin
            asyncMode = 1'b0;
            strobeOn = 1'b0;
            rdDir = 1'b0;
         end
      endcase
      nxt_c.cascN = selOn ? ~cascHit : '1;
      case (c_ff.state)
         hps_pkg::C_IDLE: begin
            nxt_c.drvN = 1'b1;
            nxt_c.ackN = 1'b1;
            if (reqSync != c_ff.reqSeen) begin
               nxt_c.reqSeen = reqSync;
               nxt_c.req.addr = l_ff.xfer.addr;
               nxt_c.req.wdata = l_ff.xfer.data;
               nxt_c.req.rd = l_ff.xfer.rd;
               nxt_c.req.wr = !l_ff.xfer.rd;
               nxt_c.isRead = l_ff.xfer.rd;
               nxt_c.isSync = 1'b1;
               nxt_c.state = hps_pkg::C_ACCESS;
            end else if (asyncMode && selOn && strobeOn && selfHit) begin
               nxt_c.req.addr = pc.addr[hps_pkg::REG_ADDR_W-1:0];
               nxt_c.req.wdata = pc.data;
               nxt_c.req.rd = rdDir;
               nxt_c.req.wr = !rdDir;
               nxt_c.isRead = rdDir;
               nxt_c.isSync = 1'b0;
               nxt_c.state = hps_pkg::C_ACCESS;
            end
         end
         hps_pkg::C_ACCESS: begin
            nxt_c.state = hps_pkg::C_CAPTURE;
         end
         hps_pkg::C_CAPTURE: begin
            nxt_c.dataOut = regRdData;
            clearHit = c_ff.isRead &&
               (c_ff.req.addr >= hps_pkg::STATUS_ADDR_LO) &&
               (c_ff.req.addr <= hps_pkg::STATUS_ADDR_HI);
            if (c_ff.isSync) begin
               nxt_c.ackTgl = !c_ff.ackTgl;
               nxt_c.state = hps_pkg::C_IDLE;
            end else begin
               nxt_c.drvN = !c_ff.isRead;
               nxt_c.ackN = 1'b0;
               nxt_c.state = hps_pkg::C_HOLD;
            end
         end
         hps_pkg::C_HOLD: begin
            if (!selOn || !strobeOn) begin
               nxt_c.drvN = 1'b1;
               nxt_c.ackN = 1'b1;
               nxt_c.state = hps_pkg::C_IDLE;
            end
         end
         default: begin
            nxt_c.state = hps_pkg::C_IDLE;
         end
      endcase
      if (!selOn) begin
         nxt_c.drvN = 1'b1;
      end
      changed = |(alarmStatus ^ c_ff.alarmPrev);
      nxt_c.alarmPrev = alarmStatus;
      if (!hwRstSync) begin
         if (c_ff.rstCnt != hps_pkg::RESET_MIN_CYC) begin
            nxt_c.rstCnt = c_ff.rstCnt + 12'h001;
         end
      end else begin
         nxt_c.rstCnt = 12'h000;
      end
      nxt_c.regDefaults = !hwRstSync &&
         (nxt_c.rstCnt == hps_pkg::RESET_MIN_CYC);
      // A change in the same cycle as a clearing read keeps the request.
      if (clearHit || nxt_c.regDefaults) begin
         nxt_c.pending = 1'b0;
      end
      if (changed) begin
         nxt_c.pending = 1'b1;
      end
      nxt_c.irqOeN = !(nxt_c.pending && globalIrqEnable);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         c_ff <= '{state: hps_pkg::C_IDLE, req: '0, isRead: 1'b0,
            isSync: 1'b0, dataOut: 8'h00, drvN: 1'b1, ackN: 1'b1,
            cascN: 5'h1f, alarmPrev: 14'h0000, pending: 1'b0,
            irqOeN: 1'b1, reqSeen: 1'b0, ackTgl: 1'b0, rstCnt: 12'h000,
            regDefaults: 1'b0};
      end else if (ce) begin
         c_ff <= nxt_c;
      end
   end

   // Host clock side: the synchronous flavour.
   always_comb begin
      logic selfHitL;
      selfHitL = 1'b0;
      nxt_l = l_ff;
      selfHitL = (devSelL == hps_pkg::DEVSEL_SELF) ||
         (devSelL == hps_pkg::DEVSEL_ALL);
      case (l_ff.state)
         hps_pkg::L_IDLE: begin
            nxt_l.ackN = 1'b1;
            nxt_l.drvN = 1'b1;
            if ((pl.busType == hps_pkg::BUS_SYNC) && !pl.selN &&
               !pl.xferStartN && selfHitL) begin
               nxt_l.xfer.rd = pl.wrRw;
               nxt_l.xfer.addr = pl.addr[hps_pkg::REG_ADDR_W-1:0];
               nxt_l.xfer.data = pl.data;
               nxt_l.reqTgl = !l_ff.reqTgl;
               nxt_l.state = hps_pkg::L_WAIT;
            end
         end
         hps_pkg::L_WAIT: begin
            // The core holds its read word until the next access begins.
            if (ackSync != l_ff.ackSeen) begin
               nxt_l.ackSeen = ackSync;
               nxt_l.rdData = c_ff.dataOut;
               nxt_l.ackN = 1'b0;
               nxt_l.drvN = !(l_ff.xfer.rd && !pl.selN);
               nxt_l.state = hps_pkg::L_ACK;
            end
         end
         hps_pkg::L_ACK: begin
            nxt_l.ackN = 1'b1;
            nxt_l.drvN = 1'b1;
            nxt_l.state = hps_pkg::L_DONE;
         end
         hps_pkg::L_DONE: begin
            if (pl.xferStartN) begin
               nxt_l.state = hps_pkg::L_IDLE;
            end
         end
         default: begin
            nxt_l.state = hps_pkg::L_IDLE;
         end
      endcase
      if (pl.selN) begin
         nxt_l.drvN = 1'b1;
      end
   end

   always_ff @(posedge hostClk or negedge resetn) begin
      if (!resetn) begin
         l_ff <= '{state: hps_pkg::L_IDLE, xfer: '0, reqTgl: 1'b0,
            ackSeen: 1'b0, ackN: 1'b1, drvN: 1'b1, rdData: 8'h00};
      end else if (ceL) begin
         l_ff <= nxt_l;
      end
   end

   // Only one side drives at a time, so the merge is a plain AND of enables.
   assign dataO = !c_ff.drvN ? c_ff.dataOut : l_ff.rdData;
   assign dataOeN = c_ff.drvN && l_ff.drvN;
   assign readyOrXferAckN = c_ff.ackN && l_ff.ackN;
   assign cascadeSelectN = c_ff.cascN;
   assign irqO = 1'b0;
   assign irqOeN = c_ff.irqOeN;
   assign regReq = c_ff.req;
   assign regDefaults = c_ff.regDefaults;
endmodule // hps_host_port

/* hps_host_port_monitor.sv */
// Checker on the host port pins of the core clock side.
// Assumes host clock paths are judged by the bench itself.
`timescale 1ns/1ps
module hps_host_port_monitor (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Watched pins.
   input wire logic selN,
   input wire logic [hps_pkg::ADDR_W-1:0] addr,
   input wire logic dataOeN,
   input wire logic readyOrXferAckN,
   input wire logic [hps_pkg::NUM_CASCADE-1:0] cascadeSelectN,
   input wire logic irqO,
   input wire logic irqOeN,
   input wire logic globalIrqEnable,
   input wire logic [hps_pkg::ALARM_W-1:0] alarmStatus,
   input wire hps_pkg::hps_reg_req_t regReq,
   input wire logic hwResetN,
   input wire logic regDefaults
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [3:0] hiCnt;
   logic [4:0] expCasc;
   logic acc;
   assign acc = regReq.wr | regReq.rd;
   always_comb begin
      expCasc = 5'h1f;
      if (addr[10:8] == 3'h7) expCasc = 5'h00;
      else if (addr[10:8] >= 3'h1 && addr[10:8] <= 3'h5)
         expCasc = ~(5'h01 << (addr[10:8] - 3'h1));
   end
   // The host side releases later than the core, so wait 15 cycles.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) hiCnt <= 4'h0;
      else if (!selN) hiCnt <= 4'h0;
      else if (hiCnt != 4'hf) hiCnt <= hiCnt + 4'h1;
   end
   property p_pin_low;
      irqO == 1'b0;
   endproperty
   a_pin_low: assert property (p_pin_low)
      else $error("interrupt pin driven high");
   property p_gated;
      !globalIrqEnable |=> irqOeN;
   endproperty
   a_gated: assert property (p_gated)
      else $error("interrupt while disabled");
   property p_raise;
      $changed(alarmStatus) && globalIrqEnable ##1 globalIrqEnable[*2]
         |=> !irqOeN;
   endproperty
   a_raise: assert property (p_raise)
      else $error("alarm change raised no interrupt");
   property p_idle;
      hiCnt == 4'hf |-> dataOeN && readyOrXferAckN && &cascadeSelectN;
   endproperty
   a_idle: assert property (p_idle)
      else $error("port active while deselected");
   property p_decode;
      (!selN && $stable(addr))[*4] |-> cascadeSelectN == expCasc;
   endproperty
   a_decode: assert property (p_decode)
      else $error("cascade selects do not match code");
   property p_req_addr;
      acc |-> regReq.addr == addr[7:0];
   endproperty
   a_req_addr: assert property (p_req_addr)
      else $error("register address differs from pins");
   property p_req_self;
      acc |-> addr[10:8] == 3'h0 || addr[10:8] == 3'h7;
   endproperty
   a_req_self: assert property (p_req_self)
      else $error("register access for another device");
   property p_req_sel;
      selN[*4] |-> !acc;
   endproperty
   a_req_sel: assert property (p_req_sel)
      else $error("register access while deselected");
   property p_defaults;
      hwResetN[*8] |-> !regDefaults;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults without hardware reset");
endmodule // hps_host_port_monitor

bind hps_host_port hps_host_port_monitor u_hps_host_port_monitor (
   .clk(clk), .resetn(resetn), .selN(selN), .addr(addr),
   .dataOeN(dataOeN), .readyOrXferAckN(readyOrXferAckN),
   .cascadeSelectN(cascadeSelectN), .irqO(irqO), .irqOeN(irqOeN),
   .globalIrqEnable(globalIrqEnable), .alarmStatus(alarmStatus),
   .regReq(regReq), .hwResetN(hwResetN), .regDefaults(regDefaults));

/* hps_pkg.sv */
// Constants, enumerations and bundles shared by the host port front end.
// Assumes one core clock at the rate below and a separate host bus clock.
package hps_pkg;

   // Address split.
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int REG_ADDR_W = 8;
   localparam int SEL_MSB = 10;
   localparam int SEL_LSB = 8;
   localparam int NUM_CASCADE = 5;
   localparam int ALARM_W = 14;

   // Device-select codes in the upper address bits.
   localparam logic [2:0] DEVSEL_SELF = 3'h0;
   localparam logic [2:0] DEVSEL_RSVD = 3'h6;
   localparam logic [2:0] DEVSEL_ALL = 3'h7;

   // Host bus flavour codes.
   localparam logic [2:0] BUS_ASYNC_STROBE = 3'h0;
   localparam logic [2:0] BUS_ASYNC_DS = 3'h1;
   localparam logic [2:0] BUS_SYNC = 3'h7;

   // Status register window whose reads release the interrupt.
   localparam logic [7:0] STATUS_ADDR_LO = 8'he0;
   localparam logic [7:0] STATUS_ADDR_HI = 8'he1;

   // Hardware reset pin must stay low for longer than this time.
   localparam int CLK_MHZ = 250;
   localparam int RESET_MIN_US = 10;
   localparam int RESET_MIN_CYC_I = RESET_MIN_US * CLK_MHZ + 1;
   localparam logic [11:0] RESET_MIN_CYC = 12'(RESET_MIN_CYC_I);

   // Pins of the host port as they arrive, before synchronising.
   typedef struct packed {
      logic selN;
      logic xferStartN;
      logic wrRw;
      logic rdWe;
      logic [2:0] busType;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } hps_pins_t;

   localparam hps_pins_t PINS_RST = '{selN: 1'b1, xferStartN: 1'b1,
      wrRw: 1'b1, rdWe: 1'b1, busType: 3'h0, addr: 11'h000, data: 8'h00};

   // Access offered to the internal register file.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [REG_ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } hps_reg_req_t;

   // Access handed from the host clock side to the core side.
   typedef struct packed {
      logic rd;
      logic [REG_ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } hps_xfer_t;

   typedef enum logic [1:0] {C_IDLE, C_ACCESS, C_CAPTURE, C_HOLD} hps_cstate_t;
   typedef enum logic [1:0] {L_IDLE, L_WAIT, L_ACK, L_DONE} hps_lstate_t;

   // Core clock state.
   typedef struct packed {
      hps_cstate_t state;
      hps_reg_req_t req;
      logic isRead;
      logic isSync;
      logic [DATA_W-1:0] dataOut;
      logic drvN;
      logic ackN;
      logic [NUM_CASCADE-1:0] cascN;
      logic [ALARM_W-1:0] alarmPrev;
      logic pending;
      logic irqOeN;
      logic reqSeen;
      logic ackTgl;
      logic [11:0] rstCnt;
      logic regDefaults;
   } hps_cst_t;

   // Host clock state.
   typedef struct packed {
      hps_lstate_t state;
      hps_xfer_t xfer;
      logic reqTgl;
      logic ackSeen;
      logic ackN;
      logic drvN;
      logic [DATA_W-1:0] rdData;
   } hps_lst_t;

endpackage

/* hps_sync2.sv */
// Two flip-flop synchroniser for a bundle of levels.
// Assumes each bit is a level; multi-bit bundles must be held stable.
`timescale 1ns/1ps
module hps_sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   input wire logic en,
   // Data.
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   // Stage 0 is the metastable catch and is read only by stage 1.
   logic [1:0][WIDTH-1:0] stage_ff;
   logic [1:0][WIDTH-1:0] nxt_stage;

   always_comb begin
      nxt_stage = stage_ff;
      nxt_stage[0] = d;
      nxt_stage[1] = stage_ff[0];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage_ff <= {RST_VAL, RST_VAL};
      end else if (en) begin
         stage_ff <= nxt_stage;
      end
   end

   assign q = stage_ff[1];
endmodule // hps_sync2

/* tb_top.sv */
// Bench: host model, register file stand-in and alarm stimulus.
// Assumes the checker binds itself to the port.
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic hostClk = 1'b0;
   logic resetn = 1'b0;
   logic hwResetN = 1'b1;
   logic global_irq_enable = 1'b0;
   logic [13:0] alarm = 14'h0000;
   logic [7:0] rdData = 8'h00;
   logic selN, xsN, wrN, rdN, ackN, oeN, irqO, irqOeN, regDef;
   logic [2:0] bt;
   logic [10:0] addr;
   logic [7:0] dI, dO;
   logic [4:0] casc;
   hps_pkg::hps_reg_req_t req;
   logic [7:0] mem [256];
   logic [7:0] shadow [256];
   int seed = 74728;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   wire irqLine = irqOeN ? 1'b1 : irqO;
   always #2 clk = ~clk;
   initial begin
      #0.7;
      forever #7.5 hostClk = ~hostClk;
   end
   hps_host_port u_hps_host_port (.clk(clk), .resetn(resetn), .ce(1'b1),
      .hostClk(hostClk), .selN(selN), .addrLatchXferStartN(xsN),
      .wrStrobeRwN(wrN), .rdStrobeWeN(rdN), .hostBusTypeSelect(bt),
      .addr(addr), .dataI(dI), .dataO(dO), .dataOeN(oeN),
      .readyOrXferAckN(ackN), .hwResetN(hwResetN),
      .cascadeSelectN(casc), .irqO(irqO), .irqOeN(irqOeN),
      .globalIrqEnable(global_irq_enable), .alarmStatus(alarm), .regReq(req),
      .regRdData(rdData), .regDefaults(regDef));
   hps_host_model u_hps_host_model (.clk(clk), .hostClk(hostClk),
      .selN(selN), .xferStartN(xsN), .wrRwN(wrN), .rdWeN(rdN),
      .busType(bt), .addr(addr), .dataI(dI), .dataO(dO), .oeN(oeN),
      .ackN(ackN), .cascN(casc));
   // Register file stand-in answers a read half a cycle later, on the falling edge of clk.
   always @(negedge clk) begin
      if (req.wr) mem[req.addr] <= req.wdata;
      rdData <= mem[req.addr];
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         stop_test();
      end
   end
   function automatic logic [4:0] expCs(input logic [2:0] c);
      if (c == 3'h7) return 5'h00;
      if (c >= 3'h1 && c <= 3'h5) return ~(5'h01 << (c - 3'h1));
      return 5'h1f;
   endfunction
   function automatic logic expAck(input logic [2:0] t, input logic [2:0] c);
      return (t != 3'h2) && (c == 3'h0 || c == 3'h7);
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      logic ok;
      logic [7:0] rd, wd, ra;
      logic [4:0] cs;
      logic [2:0] t, f;
      foreach (mem[i]) begin
         mem[i] = 8'h00;
         shadow[i] = 8'h00;
      end
      repeat (12) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      // Every flavour, including an unsupported one, against every code.
      for (int b = 0; b < 4; b++) begin
         t = (b == 3) ? 3'h2 : (b == 2) ? 3'h7 : 3'(b);
         f = (t == 3'h2) ? 3'h0 : t;
         for (int c = 0; c < 8; c++) begin
            ra = (c == 0) ? 8'h00 : (c == 7) ? 8'hff : 8'($random(seed));
            wd = 8'($random(seed));
            u_hps_host_model.access(t, 1'b0, {3'(c), ra}, wd, ok, rd, cs);
            cmp({7'h0, ok}, {7'h0, expAck(t, 3'(c))});
            cmp({3'h0, cs}, {3'h0, expCs(3'(c))});
            if (expAck(t, 3'(c))) shadow[ra] = wd;
            u_hps_host_model.access(f, 1'b1, {3'h0, ra}, 8'h00, ok, rd, cs);
            cmp(rd, shadow[ra]);
         end
      end
      @(negedge clk) global_irq_enable = 1'b1;
      alarm = 14'h2001;
      repeat (6) @(negedge clk);
      cmp({7'h0, irqLine}, 8'h00);
      u_hps_host_model.access(3'h0, 1'b1, 11'h0e0, 8'h00, ok, rd, cs);
      cmp({7'h0, irqLine}, 8'h01);
      @(negedge clk) global_irq_enable = 1'b0;
      alarm = 14'h0002;
      repeat (6) @(negedge clk);
      cmp({7'h0, irqLine}, 8'h01);
      hwResetN = 1'b0;
      repeat (2400) @(negedge clk);
      cmp({7'h0, regDef}, 8'h00);
      repeat (200) @(negedge clk);
      cmp({7'h0, regDef}, 8'h01);
      hwResetN = 1'b1;
      repeat (8) @(negedge clk);
      cmp({7'h0, regDef}, 8'h00);
      stop_test();
   end
endmodule // tb_top
